// ---- dv/tb_ldr_top.sv ----
// Self-checking bench of the loopback diagnostic register bank.
// Assumes ldr_pkg is compiled first; the bench plays register host,
// transmit source, serial line and receive sink itself.
`timescale 1ns/1ns
module tb_ldr_top import ldr_pkg::*; ();
  localparam int DW = 4;
  // Arbitrary identification values
  localparam logic [7:0] DEV_ID = 8'h3c;
  localparam logic [7:0] REV_ID = 8'h02;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [REG_AW-1:0] reg_addr = 8'h00;
  logic [REG_DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  logic [DW-1:0] tx_data = 4'h0;
  logic tx_valid = 1'b0;
  logic tx_ready;
  logic [DW-1:0] rx_data;
  logic rx_valid;
  logic rx_ready = 1'b1;
  logic rx_ser = 1'b0;
  logic rx_ser_valid = 1'b0;
  logic rx_ser_ready;
  logic tx_ser;
  logic tx_ser_valid;
  int fail_count = 0;
  int cmp_count = 0;
  logic ser_q[$];
  logic [DW-1:0] rx_q[$];

  always #2 clk = ~clk;

  ldr_top #(.DATA_W(DW), .TX_FIFO_DEPTH(4), .DEVICE_IDENTIFICATION(DEV_ID),
    .SILICON_REVISION(REV_ID)) dut (
    .i_clk(clk), .i_srst(srst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_tx_par_data(tx_data),
    .i_tx_par_valid(tx_valid), .o_tx_par_ready(tx_ready),
    .o_rx_par_data(rx_data), .o_rx_par_valid(rx_valid),
    .i_rx_par_ready(rx_ready), .i_rx_ser(rx_ser),
    .i_rx_ser_valid(rx_ser_valid), .o_rx_ser_ready(rx_ser_ready),
    .o_tx_ser(tx_ser), .o_tx_ser_valid(tx_ser_valid)
  );

  // ********************************
  // Output collectors
  // ********************************
  always @(posedge clk) begin
    if (!srst && tx_ser_valid === 1'b1) ser_q.push_back(tx_ser);
    if (!srst && rx_valid === 1'b1 && rx_ready) rx_q.push_back(rx_data);
  end

  // ********************************
  // Shared tasks
  // ********************************
  task test_done;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Refused words keep valid up, so a retry continues the same offer
  task tx_send(input logic [DW-1:0] w, input int lim, output logic ok);
    int k;
    @(posedge clk);
    tx_data <= w;
    tx_valid <= 1'b1;
    ok = 1'b0;
    k = 0;
    while (!ok && k < lim) begin
      @(negedge clk);
      ok = (tx_ready === 1'b1);
      @(posedge clk);
      k++;
    end
    if (ok) begin
      tx_valid <= 1'b0;
      tx_data <= ~w;
    end
  endtask

  task ser_send(input logic [DW-1:0] w);
    logic r;
    int i, k;
    @(posedge clk);
    for (i = DW - 1; i >= 0; i--) begin
      rx_ser <= w[i];
      rx_ser_valid <= 1'b1;
      r = 1'b0;
      k = 0;
      while (!r && k < 50) begin
        @(negedge clk);
        r = (rx_ser_ready === 1'b1);
        @(posedge clk);
        k++;
      end
      chk({7'h00, r}, 8'h01);
    end
    rx_ser_valid <= 1'b0;
    // Idle line shows the inverse so a stale bit never passes
    rx_ser <= ~w[0];
  endtask

  task get_ser(output logic [DW-1:0] got);
    int k, i;
    k = 0;
    while (ser_q.size() < DW && k < 80) begin
      @(negedge clk);
      k++;
    end
    got = 'x;
    if (ser_q.size() >= DW) begin
      for (i = DW - 1; i >= 0; i--) got[i] = ser_q.pop_front();
    end
  endtask

  task get_rx(output logic [DW-1:0] got);
    int k;
    k = 0;
    while (rx_q.size() == 0 && k < 80) begin
      @(negedge clk);
      k++;
    end
    got = 'x;
    if (rx_q.size() > 0) got = rx_q.pop_front();
  endtask

  task clr_q;
    repeat (20) @(negedge clk);
    ser_q.delete();
    rx_q.delete();
  endtask

  task flush_fifo;
    logic [7:0] d;
    int n, i;
    wr(FIFO_CTL_OFS, 8'h01);
    rd(FIFO_CTL_OFS, d);
    chk(d, 8'h03);
    wr(FIFO_CTL_OFS, 8'h00);
    // Back-to-back reads count the cycles that still show busy
    reg_addr <= FIFO_CTL_OFS;
    reg_rd <= 1'b1;
    n = 0;
    for (i = 0; i < 14; i++) begin
      @(negedge clk);
      if (reg_rdata[FLUSH_BUSY_BIT] === 1'b1) n++;
      @(posedge clk);
    end
    reg_rd <= 1'b0;
    chk(n[7:0], 8'h0a);
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task test_regs;
    logic [7:0] d;
    rd(DIAG_CTL_OFS, d);
    chk(d, 8'h00);
    @(negedge clk);
    chk(reg_rdata, 8'h00);
    rd(DEV_ID_OFS, d);
    chk(d, DEV_ID);
    rd(REV_ID_OFS, d);
    chk(d, REV_ID);
    wr(DEV_ID_OFS, 8'hff);
    wr(REV_ID_OFS, 8'h00);
    rd(DEV_ID_OFS, d);
    chk(d, DEV_ID);
    rd(REV_ID_OFS, d);
    chk(d, REV_ID);
    wr(DIAG_CTL_OFS, 8'hff);
    rd(DIAG_CTL_OFS, d);
    chk(d, 8'h07);
    wr(8'h10, 8'hff);
    rd(8'h10, d);
    chk(d, 8'h00);
    wr(DIAG_CTL_OFS, 8'h00);
    rd(DIAG_CTL_OFS, d);
    chk(d, 8'h00);
  endtask

  task test_local;
    logic ok;
    logic [DW-1:0] g;
    int i;
    wr(DIAG_CTL_OFS, 8'h04);
    clr_q();
    @(posedge clk);
    rx_ready <= 1'b0;
    tx_send(4'h1, 50, ok);
    chk({7'h00, ok}, 8'h01);
    tx_send(4'h2, 50, ok);
    chk({7'h00, ok}, 8'h01);
    tx_send(4'h3, 20, ok);
    chk({7'h00, ok}, 8'h00);
    rx_ready <= 1'b1;
    tx_send(4'h3, 50, ok);
    chk({7'h00, ok}, 8'h01);
    for (i = 1; i <= 3; i++) begin
      get_rx(g);
      chk({4'h0, g}, {4'h0, i[3:0]});
    end
    for (i = 1; i <= 3; i++) begin
      get_ser(g);
      chk({4'h0, g}, {4'h0, i[3:0]});
    end
  endtask

  task test_serial_loop;
    logic [DW-1:0] g;
    wr(DIAG_CTL_OFS, 8'h02);
    clr_q();
    ser_send(4'h6);
    get_ser(g);
    chk({4'h0, g}, 8'h06);
    get_rx(g);
    chk({4'h0, g}, 8'h06);
  endtask

  task test_dual;
    logic ok;
    logic [DW-1:0] g;
    wr(DIAG_CTL_OFS, 8'h06);
    clr_q();
    tx_send(4'h5, 50, ok);
    get_rx(g);
    chk({4'h0, g}, 8'h05);
    clr_q();
    ser_send(4'hc);
    get_ser(g);
    chk({4'h0, g}, 8'h0c);
  endtask

  task test_par_loop;
    logic [DW-1:0] g;
    wr(DIAG_CTL_OFS, 8'h01);
    flush_fifo();
    clr_q();
    chk({7'h00, tx_ready}, 8'h00);
    ser_send(4'h9);
    get_ser(g);
    chk({4'h0, g}, 8'h09);
    get_rx(g);
    chk({4'h0, g}, 8'h09);
    wr(DIAG_CTL_OFS, 8'h00);
    flush_fifo();
  endtask

  // Mid-run reset must clear loop bits and a pending flush request
  task test_reset;
    logic [7:0] d;
    wr(DIAG_CTL_OFS, 8'h07);
    wr(FIFO_CTL_OFS, 8'h01);
    repeat (3) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(DIAG_CTL_OFS, d);
    chk(d, 8'h00);
    rd(FIFO_CTL_OFS, d);
    chk(d, 8'h00);
    chk({7'h00, rx_ser_ready}, 8'h01);
  endtask

  // ********************************
  // Sequence and watchdog
  // ********************************
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_local();
    test_serial_loop();
    test_dual();
    test_par_loop();
    test_reset();
    test_done();
  end

  // The whole sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule

// ---- verilog/ldr_pkg.sv ----
// Shared constants and types of the loopback diagnostic register bank.
// Assumes a single 250 MHz core clock that also paces the transmit FIFO.
package ldr_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam logic [7:0] FIFO_CTL_OFS = 8'h03;
  localparam logic [7:0] DIAG_CTL_OFS = 8'h05;
  localparam logic [7:0] DEV_ID_OFS = 8'h3e;
  localparam logic [7:0] REV_ID_OFS = 8'h3f;

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int PAR_LOOP_BIT = 0;
  localparam int SER_LOOP_BIT = 1;
  localparam int LOC_LOOP_BIT = 2;
  localparam int LOOP_CTL_W = 3;
  localparam int FLUSH_REQ_BIT = 0;
  localparam int FLUSH_BUSY_BIT = 1;
  localparam logic [2:0] LOOP_CTL_RST = 3'h0;
  localparam logic FLUSH_REQ_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 4;
  // Transmit parallel output clock runs at the core rate here
  localparam int TXPCLK_PERIOD_NS = 4;
  localparam int FLUSH_MIN_TXPCLK = 8;
  localparam int FLUSH_MAX_TXPCLK = 10;
  // Longest time rounds down to whole core cycles
  localparam int FLUSH_MAX_CYC =
    (FLUSH_MAX_TXPCLK * TXPCLK_PERIOD_NS) / CLK_PERIOD_NS;
  // Busy drops this many cycles after the request falls
  localparam int FLUSH_DONE_CYC = FLUSH_MAX_CYC;
  localparam int FLUSH_CNT_W = 4;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_HOLD = 2'b01,
    FL_DRAIN = 2'b10
  } ldr_flush_state_type;

endpackage

// ---- verilog/ldr_rx_buf2.sv ----
// Two-entry valid/ready buffer in front of the parallel receive output.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ldr_rx_buf2 import ldr_pkg::*; #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic in_ready_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic push;
  logic pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("ldr_rx_buf2: WIDTH must be at least 1");
  end

  assign push = i_in_valid & in_ready_reg;
  assign pop = out_valid_reg & i_out_ready;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  // Ready and valid are registered from the next count, so both ends
  // see honest full and empty without a combinational path through.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_reg <= 2'h0;
      in_ready_reg <= 1'b1;
      out_valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      in_ready_reg <= (cnt_next != 2'h2);
      out_valid_reg <= (cnt_next != 2'h0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (pop && cnt_reg == 2'h2) begin
        head_reg <= tail_reg;
      end
      if (push) begin
        if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
          head_reg <= i_in_data;
        end else begin
          tail_reg <= i_in_data;
        end
      end
    end
  end

  assign o_in_ready = in_ready_reg;
  assign o_out_valid = out_valid_reg;
  assign o_out_data = head_reg;

endmodule

// ---- verilog/ldr_top.sv ----
// Loopback diagnostic control and identification registers of a serial
// transceiver, with the digital transmit and receive paths they steer.
// Assumes the register master keeps the strobe protocol and that the
// serial pins are sampled synchronously to i_clk.
//
// How it works
// - Setting the local loop bit sends parallel transmit input words to the parallel receive output.
// - While the local loop runs without either remote loop, the serial transmit output still carries the transmit path.
// - Setting the serial remote loop bit copies the serial input straight to the serial output.
// - During the serial remote loop the parallel receive output keeps carrying recovered words unless the local loop is also set.
// - Setting the parallel remote loop bit routes deserialized words through the transmit FIFO and serializer.
// - During the parallel remote loop the parallel receive output keeps carrying recovered words unless the local loop is also set.
// - The local and serial remote loops may be enabled together as a dual loop.
// - A read-only device identification byte identifies the silicon.
// - A separate read-only revision byte shows the silicon revision.
// - The FIFO flush completes within eight to ten transmit clock cycles after the flush bit falls.
`timescale 1ns/1ns
module ldr_top import ldr_pkg::*; #(
  parameter int DATA_W = 4,
  parameter int TX_FIFO_DEPTH = 4,
  // Arbitrary identification values
  parameter logic [7:0] DEVICE_IDENTIFICATION = 8'h5a,
  parameter logic [7:0] SILICON_REVISION = 8'h0a
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [REG_AW-1:0] i_reg_addr,
  input wire logic [REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [REG_DW-1:0] o_reg_rdata,
  input wire logic [DATA_W-1:0] i_tx_par_data,
  input wire logic i_tx_par_valid,
  output logic o_tx_par_ready,
  output logic [DATA_W-1:0] o_rx_par_data,
  output logic o_rx_par_valid,
  input wire logic i_rx_par_ready,
  input wire logic i_rx_ser,
  input wire logic i_rx_ser_valid,
  output logic o_rx_ser_ready,
  output logic o_tx_ser,
  output logic o_tx_ser_valid
);

  localparam int FAW = $clog2(TX_FIFO_DEPTH);
  localparam int BCW = $clog2(DATA_W + 1);
  localparam logic [BCW-1:0] BITS_FULL = BCW'(DATA_W);
  localparam logic [FAW:0] FIFO_FULL = (FAW+1)'(TX_FIFO_DEPTH);
  localparam logic [FLUSH_CNT_W-1:0] FLUSH_LOAD =
    FLUSH_CNT_W'(FLUSH_DONE_CYC - 2);
  localparam int A_FLUSH_MIN = FLUSH_MIN_TXPCLK;
  localparam int A_FLUSH_MAX = FLUSH_DONE_CYC;

  // Shifters slice [DATA_W-2:0], so a one-bit word cannot be served
  if (DATA_W < 2 || DATA_W > 8 || TX_FIFO_DEPTH < 2 ||
      (TX_FIFO_DEPTH & (TX_FIFO_DEPTH - 1)) != 0 ||
      FLUSH_DONE_CYC < 2 || FLUSH_DONE_CYC > 15) begin : g_bad_param
    $error("ldr_top: unsupported parameter values");
  end

  // ********************************
  // Registers
  // ********************************
  logic [LOOP_CTL_W-1:0] loop_ctl_reg;
  logic flush_req_reg;
  logic [REG_DW-1:0] rdata_reg;
  logic [REG_DW-1:0] rdata_next;
  logic loc_en;
  logic ser_en;
  logic par_en;
  logic flush_busy;

  assign loc_en = loop_ctl_reg[LOC_LOOP_BIT];
  assign ser_en = loop_ctl_reg[SER_LOOP_BIT];
  assign par_en = loop_ctl_reg[PAR_LOOP_BIT];

  // Only the low bits are stored; the rest of a write is dropped.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      loop_ctl_reg <= LOOP_CTL_RST;
    end else if (i_reg_wr && i_reg_addr == DIAG_CTL_OFS) begin
      loop_ctl_reg <= i_reg_wdata[LOOP_CTL_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flush_req_reg <= FLUSH_REQ_RST;
    end else if (i_reg_wr && i_reg_addr == FIFO_CTL_OFS) begin
      flush_req_reg <= i_reg_wdata[FLUSH_REQ_BIT];
    end
  end

  always_comb begin
    rdata_next = RDATA_RST;
    case (i_reg_addr)
      DIAG_CTL_OFS: rdata_next[LOOP_CTL_W-1:0] = loop_ctl_reg;
      FIFO_CTL_OFS: begin
        rdata_next[FLUSH_REQ_BIT] = flush_req_reg;
        rdata_next[FLUSH_BUSY_BIT] = flush_busy;
      end
      DEV_ID_OFS: rdata_next = DEVICE_IDENTIFICATION;
      REV_ID_OFS: rdata_next = SILICON_REVISION;
      default: rdata_next = RDATA_RST;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= RDATA_RST;
    end else if (i_reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RDATA_RST;
    end
  end

  // ********************************
  // FIFO flush sequencer
  // ********************************
  ldr_flush_state_type fl_state_reg;
  logic [FLUSH_CNT_W-1:0] fl_cnt_reg;

  // The FIFO is held empty from the request until the drain ends, so a
  // write landing mid-flush cannot leave a stale word behind.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      fl_state_reg <= FL_IDLE;
      fl_cnt_reg <= '0;
    end else begin
      case (fl_state_reg)
        FL_IDLE: begin
          if (flush_req_reg) begin
            fl_state_reg <= FL_HOLD;
          end
        end
        FL_HOLD: begin
          if (!flush_req_reg) begin
            fl_state_reg <= FL_DRAIN;
            fl_cnt_reg <= FLUSH_LOAD;
          end
        end
        FL_DRAIN: begin
          if (flush_req_reg) begin
            fl_state_reg <= FL_HOLD;
          end else if (fl_cnt_reg == '0) begin
            fl_state_reg <= FL_IDLE;
          end else begin
            fl_cnt_reg <= fl_cnt_reg - 1'b1;
          end
        end
        default: fl_state_reg <= FL_IDLE;
      endcase
    end
  end

  assign flush_busy = (fl_state_reg != FL_IDLE) || flush_req_reg;

  // ********************************
  // Serial to parallel conversion
  // ********************************
  logic [DATA_W-1:0] deser_reg;
  logic [BCW-1:0] deser_cnt_reg;
  logic [BCW-1:0] deser_cnt_next;
  logic rx_ser_ready_reg;
  logic deser_full;
  logic deser_push;
  logic rx_bit_acc;
  logic buf_in_ready;
  logic buf_in_valid;
  logic [DATA_W-1:0] buf_in_data;
  logic [FAW:0] fifo_cnt_reg;
  logic fifo_room;

  assign fifo_room = (fifo_cnt_reg != FIFO_FULL);
  assign deser_full = (deser_cnt_reg == BITS_FULL);
  assign rx_bit_acc = i_rx_ser_valid & rx_ser_ready_reg;
  // Recovered words keep flowing to the receive side in both remote loops;
  // under the local loop they are dropped there.
  assign deser_push = deser_full &&
    (loc_en || buf_in_ready) &&
    (!par_en || fifo_room || flush_busy);

  always_comb begin
    deser_cnt_next = deser_cnt_reg;
    if (deser_push) begin
      deser_cnt_next = '0;
    end else if (rx_bit_acc) begin
      deser_cnt_next = deser_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      deser_reg <= '0;
      deser_cnt_reg <= '0;
      rx_ser_ready_reg <= 1'b1;
    end else begin
      deser_cnt_reg <= deser_cnt_next;
      rx_ser_ready_reg <= (deser_cnt_next != BITS_FULL);
      if (rx_bit_acc) begin
        deser_reg <= {deser_reg[DATA_W-2:0], i_rx_ser};
      end
    end
  end

  // ********************************
  // Parallel receive output buffer
  // ********************************
  logic tx_side_ok_reg;
  logic tx_acc;

  assign tx_acc = i_tx_par_valid & o_tx_par_ready;
  // Local loop swaps the receive source for the transmit input.
  assign buf_in_valid = loc_en ? tx_acc : deser_push;
  assign buf_in_data = loc_en ? i_tx_par_data : deser_reg;

  ldr_rx_buf2 #(
    .WIDTH(DATA_W)
  ) u_rx_buf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(buf_in_valid),
    .i_in_data(buf_in_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_rx_par_valid),
    .o_out_data(o_rx_par_data),
    .i_out_ready(i_rx_par_ready)
  );

  // ********************************
  // Transmit FIFO
  // ********************************
  logic [DATA_W-1:0] fifo_mem [TX_FIFO_DEPTH];
  logic [FAW-1:0] fifo_wp_reg;
  logic [FAW-1:0] fifo_rp_reg;
  logic [FAW:0] fifo_cnt_next;
  logic fifo_wr;
  logic fifo_rd;
  logic [DATA_W-1:0] fifo_wdata;
  logic [BCW-1:0] parallel_to_serial_conv_cnt_reg;

  // Parallel remote loop feeds the FIFO from the deserializer.
  assign fifo_wr = !flush_busy &&
    (par_en ? deser_push : tx_acc);
  assign fifo_wdata = par_en ? deser_reg : i_tx_par_data;
  assign fifo_rd = !flush_busy && fifo_cnt_reg != '0 &&
    parallel_to_serial_conv_cnt_reg <= BCW'(1);

  always_comb begin
    fifo_cnt_next = fifo_cnt_reg + {{FAW{1'b0}}, fifo_wr} -
      {{FAW{1'b0}}, fifo_rd};
    if (flush_busy) begin
      fifo_cnt_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || flush_busy) begin
      fifo_wp_reg <= '0;
      fifo_rp_reg <= '0;
      fifo_cnt_reg <= '0;
    end else begin
      fifo_cnt_reg <= fifo_cnt_next;
      if (fifo_wr) begin
        fifo_wp_reg <= fifo_wp_reg + 1'b1;
      end
      if (fifo_rd) begin
        fifo_rp_reg <= fifo_rp_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (fifo_wr) begin
      fifo_mem[fifo_wp_reg] <= fifo_wdata;
    end
  end

  // Transmit input is refused from the second cycle of the parallel remote loop
  // or of a flush, so a word taken in the first cycle never reaches the FIFO;
  // a write the full FIFO cannot take is refused in time, from the next count.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_side_ok_reg <= 1'b0;
    end else begin
      tx_side_ok_reg <= !par_en && !flush_busy &&
        (fifo_cnt_next != FIFO_FULL);
    end
  end

  assign o_tx_par_ready = tx_side_ok_reg & (!loc_en | buf_in_ready);

  // ********************************
  // Parallel to serial conversion
  // ********************************
  logic [DATA_W-1:0] parallel_to_serial_conv_reg;
  logic tx_ser_reg;
  logic tx_ser_valid_reg;

  // Reloads on the last bit so words leave back to back.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      parallel_to_serial_conv_reg <= '0;
      parallel_to_serial_conv_cnt_reg <= '0;
    end else if (fifo_rd) begin
      parallel_to_serial_conv_reg <= fifo_mem[fifo_rp_reg];
      parallel_to_serial_conv_cnt_reg <= BITS_FULL;
    end else if (parallel_to_serial_conv_cnt_reg != '0) begin
      parallel_to_serial_conv_reg <= {parallel_to_serial_conv_reg[DATA_W-2:0], 1'b0};
      parallel_to_serial_conv_cnt_reg <= parallel_to_serial_conv_cnt_reg - 1'b1;
    end
  end

  // Serial remote loop bypasses the serializer entirely.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_ser_reg <= 1'b0;
      tx_ser_valid_reg <= 1'b0;
    end else if (ser_en) begin
      tx_ser_reg <= i_rx_ser;
      tx_ser_valid_reg <= i_rx_ser_valid;
    end else begin
      tx_ser_reg <= parallel_to_serial_conv_reg[DATA_W-1];
      tx_ser_valid_reg <= (parallel_to_serial_conv_cnt_reg != '0);
    end
  end

  assign o_tx_ser = tx_ser_reg;
  assign o_tx_ser_valid = tx_ser_valid_reg;
  assign o_rx_ser_ready = rx_ser_ready_reg;
  assign o_reg_rdata = rdata_reg;

  // ********************************
  // Assertions
  // ********************************
  a_local_loop_data: assert property (
    @(posedge i_clk) disable iff (i_srst)
    loc_en && tx_acc |-> buf_in_valid && buf_in_data == i_tx_par_data)
    else $error("local loop word not sent to receive side");

  a_local_tx_kept: assert property (
    @(posedge i_clk) disable iff (i_srst)
    loc_en && !par_en && !flush_busy && tx_acc |-> fifo_wr)
    else $error("local loop dropped the transmit path");

  a_serial_loop_out: assert property (
    @(posedge i_clk) disable iff (i_srst)
    ser_en && $past(ser_en) |->
      o_tx_ser == $past(i_rx_ser) &&
      o_tx_ser_valid == $past(i_rx_ser_valid))
    else $error("serial remote loop output mismatch");

  a_serial_rx_kept: assert property (
    @(posedge i_clk) disable iff (i_srst)
    ser_en && !loc_en && deser_push |->
      buf_in_valid && buf_in_data == deser_reg)
    else $error("receive words lost in serial loop");

  a_par_loop_fifo: assert property (
    @(posedge i_clk) disable iff (i_srst)
    par_en && !flush_busy && deser_push |->
      fifo_wr && fifo_wdata == deser_reg)
    else $error("parallel loop word not sent to FIFO");

  a_par_rx_kept: assert property (
    @(posedge i_clk) disable iff (i_srst)
    par_en && !loc_en && deser_full && buf_in_ready |-> buf_in_valid)
    else $error("receive words lost in parallel loop");

  a_dual_loop: assert property (
    @(posedge i_clk) disable iff (i_srst)
    loc_en && ser_en && tx_acc |->
      buf_in_valid ##1 o_tx_ser == $past(i_rx_ser))
    else $error("dual loop not working");

  a_device_identification_read: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_reg_rd && i_reg_addr == DEV_ID_OFS |=> o_reg_rdata == DEVICE_IDENTIFICATION)
    else $error("device_identification read wrong");

  a_revision_read: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_reg_rd && i_reg_addr == REV_ID_OFS |=> o_reg_rdata == SILICON_REVISION)
    else $error("silicon_revision read wrong");

  a_flush_done_time: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $fell(flush_req_reg) && !i_reg_wr |->
      ##[A_FLUSH_MIN:A_FLUSH_MAX] !flush_busy)
    else $error("flush did not finish in time");

  a_flush_empties: assert property (
    @(posedge i_clk) disable iff (i_srst)
    flush_busy |-> !fifo_wr && !fifo_rd ##1 fifo_cnt_reg == '0)
    else $error("FIFO not held empty while flushing");

  a_reset_clears: assert property (
    @(posedge i_clk)
    i_srst |=> loop_ctl_reg == LOOP_CTL_RST)
    else $error("loop bits not cleared by reset");

  a_unused_zero: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_reg_rd && i_reg_addr == DIAG_CTL_OFS |=>
      o_reg_rdata[REG_DW-1:LOOP_CTL_W] == '0)
    else $error("unused control bits read nonzero");

endmodule
